// File: bma_alu.sv
// Decimal, multiply and divide datapath with an APB register file.
// Assumes a single APB master on sys_clk; one command runs per CTRL write.
module bma_alu import bma_pkg::*; (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             divide_trap
);
	logic [15:0] acc_word, ext_word, opnd, imm, flags, result;
	logic [15:0] stack_ptr, code_seg, instr_ptr;
	logic [15:0] push_flags, push_cs, push_ip;
	logic [31:0] vector, rd_val;
	logic        trap_seen, wr_cmt, exec, wide, to_acc, imm_byte, trap_hit, mapped;
	bma_op_e     op;
	logic [15:0] next_acc, next_ext, next_res, next_flags, first;
	bma_arith_s  ar;
	logic [8:0]  bcd;
	logic [7:0]  adj;
	logic        lo_fix, hi_fix, div_zero;
	logic [15:0] ma, mb;
	logic [31:0] mul_u, dvd_u, dvs_u, q_u, r_u;
	logic signed [31:0] sa, sb, mul_s;
	logic signed [32:0] s_dvd, s_dvs, s_q, s_r;
	function automatic bma_arith_s addsub(input logic [15:0] a, input logic [15:0] b,
		input logic cin, input logic sub, input logic w);
		bma_arith_s r;
		logic [15:0] bb;
		logic        ci;
		logic [16:0] full;
		logic [8:0]  lo8;
		logic [4:0]  nib;
		bb = sub ? ~b : b;
		ci = sub ? ~cin : cin;
		full = {1'b0, a} + {1'b0, bb} + {16'h0000, ci};
		lo8 = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + {8'h00, ci};
		nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
		r.res = w ? full[15:0] : {8'h00, lo8[7:0]};
		r.carry = (w ? full[16] : lo8[8]) ^ sub;
		r.aux = nib[4] ^ sub;
		r.ovf = w ? (a[15] == bb[15]) && (full[15] != a[15])
			: (a[7] == bb[7]) && (lo8[7] != a[7]);
		return r;
	endfunction
	function automatic logic [15:0] psz(input logic [15:0] f, input logic [15:0] r,
		input logic w);
		logic [15:0] o;
		o = f;
		o[FLAG_SIGN] = w ? r[15] : r[7];
		o[FLAG_ZERO] = w ? (r == 16'h0000) : (r[7:0] == 8'h00);
		o[FLAG_PARITY] = ~^r[7:0];
		return o;
	endfunction
	// Decimal add and subtract work on one byte per command; software walks the string
	function automatic logic [8:0] bcd_byte(input logic [7:0] a, input logic [7:0] b,
		input logic cin, input logic sub);
		logic [4:0] lo, hi;
		logic       c0, c1;
		lo = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin}
			: {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		c0 = sub ? lo[4] : (lo > {1'b0, NIB_MAX});
		if (c0) lo = sub ? lo - 5'h06 : lo + 5'h06;
		hi = sub ? {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, c0}
			: {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, c0};
		c1 = sub ? hi[4] : (hi > {1'b0, NIB_MAX});
		if (c1) hi = sub ? hi - 5'h06 : hi + 5'h06;
		return {c1, hi[3:0], lo[3:0]};
	endfunction
	assign wr_cmt   = psel & penable & pready & pwrite;
	assign exec     = wr_cmt & (paddr == ADDR_CTRL);
	assign op       = bma_op_e'(pwdata[4:0]);
	assign wide     = pwdata[CTRL_WIDE];
	assign to_acc   = pwdata[CTRL_TO_ACC];
	assign imm_byte = pwdata[CTRL_IMM_BYTE];
	// Shared operand paths for products and quotients
	always_comb begin
		ma = wide ? acc_word : {8'h00, acc_word[7:0]};
		mb = wide ? opnd : {8'h00, opnd[7:0]};
		mul_u = {16'h0000, ma} * {16'h0000, mb};
		if (op == OP_PROD_IMM) begin
			sa = {{16{opnd[15]}}, opnd};
			sb = imm_byte ? {{24{imm[7]}}, imm[7:0]} : {{16{imm[15]}}, imm};
		end else begin
			sa = wide ? {{16{acc_word[15]}}, acc_word} : {{24{acc_word[7]}}, acc_word[7:0]};
			sb = wide ? {{16{opnd[15]}}, opnd} : {{24{opnd[7]}}, opnd[7:0]};
		end
		mul_s = sa * sb;
		// Zero divisor is forced to one so the quotient stays defined; it traps anyway
		div_zero = wide ? (opnd == 16'h0000) : (opnd[7:0] == 8'h00);
		dvd_u = wide ? {ext_word, acc_word} : {16'h0000, acc_word};
		dvs_u = div_zero ? 32'h0000_0001 : {16'h0000, mb};
		q_u = dvd_u / dvs_u;
		r_u = dvd_u % dvs_u;
		s_dvd = wide ? {ext_word[15], ext_word, acc_word} : {{17{acc_word[15]}}, acc_word};
		s_dvs = div_zero ? 33'sh0_0000_0001 : {sb[31], sb};
		s_q = s_dvd / s_dvs;
		s_r = s_dvd % s_dvs;
	end
	always_comb begin
		next_acc = acc_word;
		next_ext = ext_word;
		next_res = result;
		next_flags = flags;
		trap_hit = 1'b0;
		first = to_acc ? acc_word : opnd;
		bcd = bcd_byte(opnd[7:0], imm[7:0], flags[FLAG_CARRY], op != OP_BCD_ADD);
		adj = acc_word[7:0];
		lo_fix = (acc_word[3:0] > NIB_MAX) || flags[FLAG_AUX];
		hi_fix = (acc_word[7:0] > PK_LIMIT) || flags[FLAG_CARRY];
		ar = addsub(first, (op == OP_ADD_ONE || op == OP_SUB_ONE) ? ONE_STEP : imm,
			(op == OP_SUB_BORROW) & flags[FLAG_CARRY], op != OP_ADD_ONE, wide);
		case (op)
			OP_SUB_BORROW, OP_COMPARE, OP_ADD_ONE, OP_SUB_ONE: begin
				next_flags = psz(flags, ar.res, wide);
				next_flags[FLAG_CARRY] = ar.carry;
				next_flags[FLAG_AUX] = ar.aux;
				next_flags[FLAG_OVF] = ar.ovf;
				if (op != OP_COMPARE) begin
					if (to_acc) next_acc = wide ? ar.res : {acc_word[15:8], ar.res[7:0]};
					else next_res = ar.res;
				end
			end
			OP_BCD_ADD, OP_BCD_SUB, OP_BCD_COMPARE: begin
				next_flags[FLAG_CARRY] = bcd[8];
				// Zero only clears, so a multi-byte string keeps it across bytes
				if (bcd[7:0] != 8'h00) next_flags[FLAG_ZERO] = 1'b0;
				if (op != OP_BCD_COMPARE) next_res = {8'h00, bcd[7:0]};
			end
			OP_UNP_ADD_ADJ: begin
				if (lo_fix) begin
					next_acc = {acc_word[15:8] + 8'h01, (acc_word[7:0] + ADJ_LO) & LOW_MASK};
					next_flags[FLAG_AUX] = 1'b1;
					next_flags[FLAG_CARRY] = 1'b1;
				end else begin
					next_acc[7:0] = acc_word[7:0] & LOW_MASK;
					next_flags[FLAG_AUX] = 1'b0;
					next_flags[FLAG_CARRY] = 1'b0;
				end
			end
			OP_PK_ADD_ADJ, OP_PK_SUB_ADJ: begin
				if (lo_fix) begin
					adj = (op == OP_PK_ADD_ADJ) ? adj + ADJ_LO : adj - ADJ_LO;
					next_flags[FLAG_CARRY] = flags[FLAG_CARRY] | flags[FLAG_AUX];
					next_flags[FLAG_AUX] = 1'b1;
				end
				if (hi_fix) begin
					adj = (op == OP_PK_ADD_ADJ) ? adj + ADJ_HI : adj - ADJ_HI;
					next_flags[FLAG_CARRY] = 1'b1;
				end
				next_acc[7:0] = adj;
				next_flags = psz(next_flags, {8'h00, adj}, 1'b0);
			end
			OP_PROD_U: begin
				if (wide) {next_ext, next_acc} = mul_u;
				else next_acc = mul_u[15:0];
				next_flags[FLAG_CARRY] = wide ? (mul_u[31:16] != 16'h0000) : (mul_u[15:8] != 8'h00);
				next_flags[FLAG_OVF] = next_flags[FLAG_CARRY];
			end
			OP_PROD_S: begin
				if (wide) {next_ext, next_acc} = mul_s;
				else next_acc = mul_s[15:0];
				next_flags[FLAG_CARRY] = wide ? (mul_s[31:16] != {16{mul_s[15]}})
					: (mul_s[15:8] != {8{mul_s[7]}});
				next_flags[FLAG_OVF] = next_flags[FLAG_CARRY];
			end
			OP_PROD_IMM: begin
				next_res = mul_s[15:0];
				next_flags[FLAG_CARRY] = mul_s[31:16] != {16{mul_s[15]}};
				next_flags[FLAG_OVF] = next_flags[FLAG_CARRY];
			end
			OP_QUOT_U: begin
				if (div_zero || (wide ? q_u[31:16] != 16'h0000 : q_u[31:8] != 24'h000000))
					trap_hit = 1'b1;
				else if (wide) {next_ext, next_acc} = {r_u[15:0], q_u[15:0]};
				else next_acc = {r_u[7:0], q_u[7:0]};
			end
			OP_QUOT_S: begin
				if (div_zero || s_q > (wide ? SQ_W_MAX : SQ_B_MAX)
					|| s_q < (wide ? SQ_W_MIN : SQ_B_MIN))
					trap_hit = 1'b1;
				else if (wide) {next_ext, next_acc} = {s_r[15:0], s_q[15:0]};
				else next_acc = {s_r[7:0], s_q[7:0]};
			end
			OP_SPLIT: begin
				next_acc = {acc_word[7:0] / TEN, acc_word[7:0] % TEN};
				next_flags = psz(flags, {8'h00, next_acc[7:0]}, 1'b0);
			end
			OP_MERGE: begin
				next_acc = {8'h00, acc_word[15:8] * TEN + acc_word[7:0]};
				next_flags = psz(flags, next_acc, 1'b0);
			end
			OP_SEXT_B: next_acc[15:8] = {8{acc_word[7]}};
			OP_SEXT_W: next_ext = {16{acc_word[15]}};
			OP_ROT_L: begin
				next_res = {8'h00, opnd[3:0], acc_word[3:0]};
				next_acc[3:0] = opnd[7:4];
			end
			OP_ROT_R: begin
				next_res = {8'h00, acc_word[3:0], opnd[7:4]};
				next_acc[3:0] = opnd[3:0];
			end
			default: ;
		endcase
	end
	// Arithmetic state; commands and direct writes never coincide on APB
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			acc_word <= WORD_RST;
			ext_word <= WORD_RST;
			result <= WORD_RST;
			flags <= FLAGS_RST;
		end else if (exec) begin
			acc_word <= next_acc;
			ext_word <= next_ext;
			result <= next_res;
			flags <= trap_hit ? flags & TRAP_CLR_MASK : next_flags;
		end else if (wr_cmt) begin
			if (paddr == ADDR_ACC) acc_word <= pwdata[15:0];
			if (paddr == ADDR_EXT) ext_word <= pwdata[15:0];
			if (paddr == ADDR_FLAGS) flags <= pwdata[15:0];
		end
	end
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			opnd <= WORD_RST;
			imm <= WORD_RST;
			vector <= {WORD_RST, WORD_RST};
		end else if (wr_cmt) begin
			if (paddr == ADDR_OPND) opnd <= pwdata[15:0];
			if (paddr == ADDR_IMM) imm <= pwdata[15:0];
			if (paddr == ADDR_VECTOR) vector <= pwdata;
		end
	end
	// Divide trap frame: flags, code segment, pointer, in push order
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			stack_ptr <= WORD_RST;
			code_seg <= WORD_RST;
			instr_ptr <= WORD_RST;
			push_flags <= WORD_RST;
			push_cs <= WORD_RST;
			push_ip <= WORD_RST;
		end else if (exec && trap_hit) begin
			stack_ptr <= stack_ptr - TRAP_FRAME;
			push_flags <= flags;
			push_cs <= code_seg;
			push_ip <= instr_ptr;
			code_seg <= vector[31:16];
			instr_ptr <= vector[15:0];
		end else if (wr_cmt) begin
			if (paddr == ADDR_STACK) stack_ptr <= pwdata[15:0];
			if (paddr == ADDR_CODE_SEG) code_seg <= pwdata[15:0];
			if (paddr == ADDR_INSTR_PTR) instr_ptr <= pwdata[15:0];
		end
	end
	// Sticky trap bit: a new trap beats a write-one clear in the same cycle
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			trap_seen <= 1'b0;
			divide_trap <= 1'b0;
		end else begin
			trap_seen <= (exec && trap_hit)
				|| (trap_seen && !(wr_cmt && paddr == ADDR_STATUS && pwdata[0]));
			divide_trap <= exec && trap_hit;
		end
	end
	always_comb begin
		mapped = 1'b1;
		rd_val = 32'h0000_0000;
		case (paddr)
			ADDR_CTRL: rd_val = 32'h0000_0000;
			ADDR_ACC: rd_val = {16'h0000, acc_word};
			ADDR_EXT: rd_val = {16'h0000, ext_word};
			ADDR_OPND: rd_val = {16'h0000, opnd};
			ADDR_IMM: rd_val = {16'h0000, imm};
			ADDR_FLAGS: rd_val = {16'h0000, flags};
			ADDR_STACK: rd_val = {16'h0000, stack_ptr};
			ADDR_CODE_SEG: rd_val = {16'h0000, code_seg};
			ADDR_INSTR_PTR: rd_val = {16'h0000, instr_ptr};
			ADDR_VECTOR: rd_val = vector;
			ADDR_RESULT: rd_val = {16'h0000, result};
			ADDR_STATUS: rd_val = {31'h0000_0000, trap_seen};
			ADDR_PUSH_FLAGS: rd_val = {16'h0000, push_flags};
			ADDR_PUSH_CS: rd_val = {16'h0000, push_cs};
			ADDR_PUSH_IP: rd_val = {16'h0000, push_ip};
			default: mapped = 1'b0;
		endcase
	end
	// One wait state keeps pready, prdata and pslverr straight from flops
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
			prdata <= (psel && penable && !pready && !pwrite) ? rd_val : 32'h0000_0000;
			pslverr <= psel && penable && !pready && !mapped;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence s_exec(bma_op_e o);
		exec && op == o;
	endsequence
	AST_SEXT_B: assert property (s_exec(OP_SEXT_B) |=>
		acc_word[15:8] == ($past(acc_word[7]) ? 8'hFF : 8'h00) && flags == $past(flags))
		else $error("byte sign extend wrong");
	AST_SEXT_W: assert property (s_exec(OP_SEXT_W) |=>
		ext_word == {16{$past(acc_word[15])}} && flags == $past(flags))
		else $error("word sign extend wrong");
	AST_TRAP: assert property (exec && trap_hit |=>
		stack_ptr == $past(stack_ptr) - TRAP_FRAME && instr_ptr == $past(vector[15:0])
		&& !flags[FLAG_INT_EN] && !flags[FLAG_STEP] && divide_trap ##1 !divide_trap)
		else $error("divide trap frame wrong");
	AST_PROD_U_B: assert property (s_exec(OP_PROD_U) ##0 !wide |=>
		acc_word == $past(acc_word[7:0]) * $past(opnd[7:0])
		&& flags[FLAG_CARRY] == (acc_word[15:8] != 8'h00))
		else $error("byte unsigned product wrong");
	AST_QUOT_U_B: assert property (s_exec(OP_QUOT_U) ##0 (!wide && !trap_hit) |=>
		{8'h00, acc_word[7:0]} * $past(opnd[7:0]) + acc_word[15:8] == $past(acc_word))
		else $error("byte unsigned quotient wrong");
	AST_SPLIT: assert property (s_exec(OP_SPLIT) |=>
		acc_word[15:8] * TEN + acc_word[7:0] == $past(acc_word[7:0]) && acc_word[7:0] < TEN)
		else $error("split wrong");
	AST_MERGE: assert property (s_exec(OP_MERGE) |=>
		acc_word[15:8] == 8'h00 && acc_word[7:0] == 8'($past(acc_word[15:8]) * TEN
		+ $past(acc_word[7:0]))) else $error("merge wrong");
	AST_COMPARE: assert property (s_exec(OP_COMPARE) |=>
		acc_word == $past(acc_word) && result == $past(result)) else $error("compare stored a value");
	AST_ADD_ONE: assert property (s_exec(OP_ADD_ONE) ##0 (wide && !to_acc) |=>
		result == $past(opnd) + ONE_STEP) else $error("add one wrong");
	sequence s_wait_cycle;
		psel && penable && !pready;
	endsequence
	AST_APB_ONE_WAIT: assert property (s_wait_cycle ##1 psel && penable |-> pready)
		else $error("apb answer late");
endmodule // bma_alu

// File: bma_alu_tb_top.sv
// Self-checking bench for the decimal/multiply/divide datapath.
// Assumes bma_pkg and the APB master model bma_cpu_model.
module bma_alu_tb_top import bma_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk;
	logic        reset;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        divide_trap;
	logic [31:0] seed;
	int          mismatches;
	int          comparisons;

	bma_alu i_bma_alu (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .divide_trap(divide_trap));
	bma_cpu_model i_bma_cpu_model (.sys_clk(sys_clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	function automatic logic [15:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction

	// Remainder in the upper half, quotient in the lower half
	function automatic logic [31:0] quot_rem(input logic [31:0] n, input logic [31:0] dv);
		return {16'(n % dv), 16'(n / dv)};
	endfunction

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		i_bma_cpu_model.xfer(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		i_bma_cpu_model.xfer(1'b0, a, 32'h0, q, e);
	endtask

	// Load operands and flags, issue one command, check one masked register
	task automatic t(input logic [15:0] c, a, x, o, i, f, input logic [7:0] ad,
			input logic [15:0] m, e);
		logic [31:0] q;
		wr(ADDR_ACC, {16'h0, a});
		wr(ADDR_EXT, {16'h0, x});
		wr(ADDR_OPND, {16'h0, o});
		wr(ADDR_IMM, {16'h0, i});
		wr(ADDR_FLAGS, {16'h0, f});
		wr(ADDR_CTRL, {16'h0, c});
		rd(ad, q);
		chk($sformatf("cmd %h reg %h", c, ad), {16'h0, e}, q & {16'h0, m});
	endtask

	// Divide overflow: pulse, stacked frame, vector load, cleared enables
	task automatic trap(input logic [15:0] c, a, x, o);
		logic [7:0]  ra[10];
		logic [31:0] rv[10];
		logic [31:0] q;
		ra = '{ADDR_STACK, ADDR_CODE_SEG, ADDR_INSTR_PTR, ADDR_VECTOR, ADDR_EXT,
			ADDR_ACC, ADDR_OPND, ADDR_FLAGS, ADDR_STATUS, ADDR_CTRL};
		rv = '{32'h0100, 32'h1111, 32'h2222, 32'hABCD5678, {16'h0, x}, {16'h0, a},
			{16'h0, o}, 32'h0301, 32'h1, {16'h0, c}};
		for (int k = 0; k < 10; k++) begin
			wr(ra[k], rv[k]);
		end
		@(posedge sys_clk);
		chk("trap pulse", 32'h1, {31'h0, divide_trap});
		@(posedge sys_clk);
		chk("trap pulse end", 32'h0, {31'h0, divide_trap});
		ra = '{ADDR_STACK, ADDR_CODE_SEG, ADDR_INSTR_PTR, ADDR_FLAGS, ADDR_PUSH_FLAGS,
			ADDR_PUSH_CS, ADDR_PUSH_IP, ADDR_STATUS, ADDR_STATUS, ADDR_STATUS};
		rv = '{32'h00FA, 32'hABCD, 32'h5678, 32'h0001, 32'h0301, 32'h1111, 32'h2222,
			32'h1, 32'h1, 32'h1};
		for (int k = 0; k < 8; k++) begin
			rd(ra[k], q);
			chk("trap frame", rv[k], q);
		end
		// Sticky status cleared by writing one
		wr(ADDR_STATUS, 32'h1);
		rd(ADDR_STATUS, q);
		chk("status clear", 32'h0, q & 32'h1);
	endtask

	task automatic results();
		$display("counts: %0d mismatches, %0d comparisons", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge sys_clk);
		mismatches++;
		results();
	end

	initial begin
		logic [31:0] q;
		logic        e;
		logic [15:0] a, o, x, i;
		logic [31:0] d;
		mismatches  = 0;
		comparisons = 0;
		seed        = 32'h61;
		reset       = 1'b1;
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		for (int k = 1; k < 15; k++) begin
			rd(8'(k * 4), q);
			chk("reset value", 32'h0, q);
		end
		i_bma_cpu_model.xfer(1'b0, 8'h3C, 32'h0, q, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		$display("test reset and bus done");
		t(16'h0301,16'h1000,16'h0,16'h0,16'h0001,16'h0001,ADDR_ACC,16'hFFFF,16'h0FFE);
		t(16'h0201,16'h1205,16'h0,16'h0,16'h0006,16'h0,ADDR_FLAGS,16'h0001,16'h0001);
		t(16'h0002,16'h0,16'h0,16'h0038,16'h0045,16'h0,ADDR_RESULT,16'h00FF,16'h0083);
		t(16'h0003,16'h0,16'h0,16'h0045,16'h0038,16'h0,ADDR_RESULT,16'h00FF,16'h0007);
		t(16'h0004,16'h0,16'h0,16'h0038,16'h0045,16'h0,ADDR_FLAGS,16'h0001,16'h0001);
		t(16'h0004,16'h0,16'h0,16'h0038,16'h0045,16'h0,ADDR_RESULT,16'h00FF,16'h0007);
		t(16'h0205,16'h020B,16'h0,16'h0,16'h0,16'h0,ADDR_ACC,16'hFFFF,16'h0301);
		t(16'h0205,16'h020B,16'h0,16'h0,16'h0,16'h0,ADDR_FLAGS,16'h0011,16'h0011);
		t(16'h0206,16'h00AB,16'h0,16'h0,16'h0,16'h0,ADDR_ACC,16'h00FF,16'h0011);
		t(16'h0206,16'h0045,16'h0,16'h0,16'h0,16'h0,ADDR_ACC,16'h00FF,16'h0045);
		t(16'h0207,16'h00AB,16'h0,16'h0,16'h0,16'h0,ADDR_ACC,16'h00FF,16'h0045);
		t(16'h0207,16'h00AB,16'h0,16'h0,16'h0,16'h0,ADDR_FLAGS,16'h0011,16'h0011);
		t(16'h0308,16'hFFFF,16'h0,16'h0,16'h0,16'h0,ADDR_FLAGS,16'h0040,16'h0040);
		t(16'h0309,16'h0,16'h0,16'h0,16'h0,16'h0,ADDR_ACC,16'hFFFF,16'hFFFF);
		t(16'h0208,16'h12FF,16'h0,16'h0,16'h0,16'h0,ADDR_ACC,16'hFFFF,16'h1200);
		t(16'h0108,16'h0,16'h0,16'h00FF,16'h0,16'h0,ADDR_RESULT,16'hFFFF,16'h0100);
		t(16'h020B,16'h00FE,16'h0,16'h0003,16'h0,16'h0,ADDR_ACC,16'hFFFF,16'hFFFA);
		t(16'h020B,16'h0040,16'h0,16'h0004,16'h0,16'h0,ADDR_FLAGS,16'h0801,16'h0801);
		t(16'h030B,16'hFFFF,16'h0,16'h0002,16'h0,16'h0,ADDR_EXT,16'hFFFF,16'hFFFF);
		t(16'h030B,16'hFFFF,16'h0,16'h0002,16'h0,16'h0,ADDR_FLAGS,16'h0801,16'h0);
		t(16'h040C,16'h0,16'h0,16'h0003,16'h00FB,16'h0,ADDR_RESULT,16'hFFFF,16'hFFF1);
		t(16'h000C,16'h0,16'h0,16'h0100,16'h0100,16'h0,ADDR_FLAGS,16'h0801,16'h0801);
		t(16'h000C,16'h0,16'h0,16'h0003,16'h0005,16'h0,ADDR_FLAGS,16'h0801,16'h0);
		t(16'h020E,16'hFF9C,16'h0,16'h0007,16'h0,16'h0,ADDR_ACC,16'hFFFF,16'hFEF2);
		t(16'h030E,16'hFF9C,16'hFFFF,16'h0007,16'h0,16'h0,ADDR_EXT,16'hFFFF,16'hFFFE);
		t(16'h0210,16'h0307,16'h0,16'h0,16'h0,16'h0,ADDR_ACC,16'hFFFF,16'h0025);
		t(16'h0211,16'h1280,16'h0,16'h0,16'h0,16'h0011,ADDR_ACC,16'hFFFF,16'hFF80);
		t(16'h0211,16'h347F,16'h0,16'h0,16'h0,16'h0011,ADDR_FLAGS,16'hFFFF,16'h0011);
		t(16'h0312,16'h8000,16'h0,16'h0,16'h0,16'h0,ADDR_EXT,16'hFFFF,16'hFFFF);
		t(16'h0312,16'h7FFF,16'h1234,16'h0,16'h0,16'h0,ADDR_EXT,16'hFFFF,16'h0);
		t(16'h0313,16'h0005,16'h0,16'h0,16'h0007,16'h0,ADDR_ACC,16'hFFFF,16'h0005);
		t(16'h0313,16'h0005,16'h0,16'h0,16'h0007,16'h0,ADDR_FLAGS,16'h0041,16'h0001);
		t(16'h0313,16'h0009,16'h0,16'h0,16'h0009,16'h0,ADDR_FLAGS,16'h0041,16'h0040);
		t(16'h0214,16'h0003,16'h0,16'h0012,16'h0,16'h0,ADDR_RESULT,16'h00FF,16'h0023);
		t(16'h0215,16'h0003,16'h0,16'h0012,16'h0,16'h0,ADDR_ACC,16'h000F,16'h0002);
		t(16'h0216,16'h1234,16'h0,16'h0,16'h0,16'h0,ADDR_ACC,16'hFFFF,16'h1234);
		$display("test directed done");
		trap(16'h020D, 16'h1000, 16'h0, 16'h0001);
		trap(16'h030D, 16'h0, 16'h0002, 16'h0002);
		trap(16'h020E, 16'h4000, 16'h0, 16'h0001);
		$display("test divide trap done");
		for (int k = 0; k < 12; k++) begin
			a = rnd();
			o = rnd();
			x = rnd();
			i = rnd();
			d = {24'h0, a[7:0]} * {24'h0, o[7:0]};
			t(16'h020A,a,16'h0,o,16'h0,16'h0,ADDR_ACC,16'hFFFF,d[15:0]);
			t(16'h020A,a,16'h0,o,16'h0,16'h0,ADDR_FLAGS,16'h0801,(|d[15:8]) ? 16'h0801 : 16'h0);
			d = {16'h0, a} * {16'h0, o};
			t(16'h030A,a,16'h0,o,16'h0,16'h0,ADDR_EXT,16'hFFFF,d[31:16]);
			t(16'h030A,a,16'h0,o,16'h0,16'h0,ADDR_FLAGS,16'h0801,(|d[31:16]) ? 16'h0801 : 16'h0);
			o = o | 16'h0001;
			a[15:8] = a[15:8] % o[7:0];
			d = quot_rem({16'h0, a}, {24'h0, o[7:0]});
			t(16'h020D,a,16'h0,o,16'h0,16'h0,ADDR_ACC,16'hFFFF,{d[23:16], d[7:0]});
			x = x % o;
			d = quot_rem({x, a}, {16'h0, o});
			t(16'h030D,a,x,o,16'h0,16'h0,ADDR_ACC,16'hFFFF,d[15:0]);
			d = quot_rem({24'h0, a[7:0]}, 32'h0A);
			t(16'h020F,a,16'h0,16'h0,16'h0,16'h0,ADDR_ACC,16'hFFFF,{d[7:0], d[23:16]});
			t(16'h0301,a,16'h0,16'h0,i,{15'h0, x[0]},ADDR_ACC,16'hFFFF,a - i - {15'h0, x[0]});
		end
		$display("test random done");
		results();
	end
endmodule // bma_alu_tb_top

// File: bma_cpu_model.sv
// APB master standing in for the processor sequencer.
// Assumes one caller at a time; signals change only after rising edges.
module bma_cpu_model (
	input  wire logic        sys_clk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
	end

	// No latency assumed; only the bench watchdog ends a wait
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Released data flips so stale values are never mistaken for held ones
		pwdata  <= ~d;
	endtask
endmodule // bma_cpu_model

// File: bma_pkg.sv
// Constants, op codes and carriers for the decimal/multiply/divide datapath.
// Assumes an APB master with 32-bit data and byte addresses.
package bma_pkg;
	localparam logic [7:0] ADDR_CTRL       = 8'h00;
	localparam logic [7:0] ADDR_ACC        = 8'h04;
	localparam logic [7:0] ADDR_EXT        = 8'h08;
	localparam logic [7:0] ADDR_OPND       = 8'h0C;
	localparam logic [7:0] ADDR_IMM        = 8'h10;
	localparam logic [7:0] ADDR_FLAGS      = 8'h14;
	localparam logic [7:0] ADDR_STACK      = 8'h18;
	localparam logic [7:0] ADDR_CODE_SEG   = 8'h1C;
	localparam logic [7:0] ADDR_INSTR_PTR  = 8'h20;
	localparam logic [7:0] ADDR_VECTOR     = 8'h24;
	localparam logic [7:0] ADDR_RESULT     = 8'h28;
	localparam logic [7:0] ADDR_STATUS     = 8'h2C;
	localparam logic [7:0] ADDR_PUSH_FLAGS = 8'h30;
	localparam logic [7:0] ADDR_PUSH_CS    = 8'h34;
	localparam logic [7:0] ADDR_PUSH_IP    = 8'h38;

	localparam int CTRL_WIDE     = 8;
	localparam int CTRL_TO_ACC   = 9;
	localparam int CTRL_IMM_BYTE = 10;

	localparam int FLAG_CARRY  = 0;
	localparam int FLAG_PARITY = 2;
	localparam int FLAG_AUX    = 4;
	localparam int FLAG_ZERO   = 6;
	localparam int FLAG_SIGN   = 7;
	localparam int FLAG_STEP   = 8;
	localparam int FLAG_INT_EN = 9;
	localparam int FLAG_OVF    = 11;

	localparam logic [15:0] FLAGS_RST      = 16'h0000;
	localparam logic [15:0] WORD_RST       = 16'h0000;
	localparam logic [15:0] TRAP_CLR_MASK  = 16'hFCFF;
	localparam logic [15:0] TRAP_FRAME     = 16'h0006;
	localparam logic [15:0] ONE_STEP       = 16'h0001;
	localparam logic [3:0]  NIB_MAX        = 4'h9;
	localparam logic [7:0]  ADJ_LO         = 8'h06;
	localparam logic [7:0]  ADJ_HI         = 8'h60;
	localparam logic [7:0]  PK_LIMIT       = 8'h9F;
	localparam logic [7:0]  LOW_MASK       = 8'h0F;
	localparam logic [7:0]  TEN            = 8'h0A;
	localparam logic signed [32:0] SQ_B_MAX = 33'sh0_0000_007F;
	localparam logic signed [32:0] SQ_B_MIN = -33'sh0_0000_0080;
	localparam logic signed [32:0] SQ_W_MAX = 33'sh0_0000_7FFF;
	localparam logic signed [32:0] SQ_W_MIN = -33'sh0_0000_8000;

	typedef enum logic [4:0] {
		OP_NONE, OP_SUB_BORROW, OP_BCD_ADD, OP_BCD_SUB, OP_BCD_COMPARE,
		OP_UNP_ADD_ADJ, OP_PK_ADD_ADJ, OP_PK_SUB_ADJ, OP_ADD_ONE, OP_SUB_ONE,
		OP_PROD_U, OP_PROD_S, OP_PROD_IMM, OP_QUOT_U, OP_QUOT_S,
		OP_SPLIT, OP_MERGE, OP_SEXT_B, OP_SEXT_W, OP_COMPARE, OP_ROT_L, OP_ROT_R
	} bma_op_e;

	typedef struct packed {
		logic [15:0] res;
		logic        carry;
		logic        aux;
		logic        ovf;
	} bma_arith_s;
endpackage
